// ===== core/cio_top.sv
// Notes on behaviour
// - Field is bits 7..4; codes 0000 and 0100 give compare with pin off.
// - Codes 0001..0011 drive the pin low before any match.
// - Codes 0101..0111 drive the pin high before any match.
// - Compare mode, low bits 01: pin goes low on each match.
// - Compare mode, low bits 10: pin goes high on each match.
// - Compare mode, low bits 11: pin toggles on each match.
// - Capture mode, low bits 00: counter copied on a rising pin edge.
// - Capture mode, low bits 01: counter copied on a falling pin edge.
// - Capture mode, bit 5 set: capture on both edges, bit 4 ignored.
// - Channel 2 register B: bit 6 ignored in capture, source is own pin.
// - Channel 3 B and D: codes 10xx capture from their own pin.
// - Channel 3 B: codes 11xx capture on the channel 4 count clock.
// - Channel 3 D: codes 11xx capture on each channel 4 count step.
// - Channel 4 prescale 000 makes cascaded capture invalid: no capture.
// - Buffer mode on channel 3 stops register D capture and compare.
`timescale 1ns/1ps
module cio_top (
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_sys_rst,
    // Register port
    input  wire logic [cio_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic [cio_pkg::DATA_W-1:0]  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [cio_pkg::DATA_W-1:0]  o_rdata,
    // Counters of the same clock
    input  wire logic [cio_pkg::CNT_W-1:0]   i_ch2_count,
    input  wire logic [cio_pkg::CNT_W-1:0]   i_ch3_count,
    input  wire logic                        i_ch4_count_step,
    // Timer pins
    input  wire logic                        i_ch2_pin_b,
    output logic                             o_ch2_pin_b,
    output logic                             o_ch2_pin_b_oe_n,
    input  wire logic                        i_ch3_pin_b,
    output logic                             o_ch3_pin_b,
    output logic                             o_ch3_pin_b_oe_n,
    input  wire logic                        i_ch3_pin_d,
    output logic                             o_ch3_pin_d,
    output logic                             o_ch3_pin_d_oe_n,
    // Capture events
    output logic                             o_ch2_capture_b,
    output logic                             o_ch3_capture_b,
    output logic                             o_ch3_capture_d
);
    import cio_pkg::*;

    // ========================================================
    // Per-unit wiring
    // ========================================================
    logic [N_UNIT-1:0] pin_in;
    logic [N_UNIT-1:0] pin_lvl;
    logic [N_UNIT-1:0] pin_oe_n;
    logic [N_UNIT-1:0] pin_sync;
    logic [N_UNIT-1:0] rise;
    logic [N_UNIT-1:0] fall;
    logic [N_UNIT-1:0] ctl_wr;
    logic [N_UNIT-1:0] active;
    logic [N_UNIT-1:0] match;
    logic [N_UNIT-1:0] capture;
    logic [N_UNIT-1:0] greg_wr;
    logic [CTL_W-1:0]  ctl     [N_UNIT];
    logic [CNT_W-1:0]  count   [N_UNIT];
    logic [CNT_W-1:0]  prev_r  [N_UNIT];
    logic [CNT_W-1:0]  greg_r  [N_UNIT];

    logic              buf_mode_r;
    logic [2:0]        psc_r;
    logic              casc_evt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    assign pin_in[U_CH2_B] = i_ch2_pin_b;
    assign pin_in[U_CH3_B] = i_ch3_pin_b;
    assign pin_in[U_CH3_D] = i_ch3_pin_d;

    assign count[U_CH2_B] = i_ch2_count;
    assign count[U_CH3_B] = i_ch3_count;
    assign count[U_CH3_D] = i_ch3_count;

    // ========================================================
    // Write decode
    // ========================================================
    always_comb begin
        ctl_wr  = '0;
        greg_wr = '0;
        if (i_wr) begin
            if (i_addr == OFS_CH2_IOC)
                ctl_wr[U_CH2_B] = 1'b1;
            else if (i_addr == OFS_CH3_IOC_HIGH)
                ctl_wr[U_CH3_B] = 1'b1;
            else if (i_addr == OFS_CH3_IOC_LOW)
                ctl_wr[U_CH3_D] = 1'b1;
            else if (i_addr == OFS_CH2_GREG_B)
                greg_wr[U_CH2_B] = 1'b1;
            else if (i_addr == OFS_CH3_GREG_B)
                greg_wr[U_CH3_B] = 1'b1;
            else if (i_addr == OFS_CH3_GREG_D)
                greg_wr[U_CH3_D] = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            buf_mode_r <= 1'b0;
        end else if (i_wr && i_addr == OFS_CH3_MODE) begin
            buf_mode_r <= i_wdata[BUF_MODE_BIT];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            psc_r <= PSC_RST;
        end else if (i_wr && i_addr == OFS_CH4_CNT_CTL) begin
            psc_r <= i_wdata[PSC_MSB:PSC_LSB];
        end
    end

    // Undivided count clock cannot be seen as discrete steps
    assign casc_evt = i_ch4_count_step && (psc_r != PSC_UNDIVIDED);

    // Register D serving as a buffer is out of the pin's hands
    assign active[U_CH2_B] = 1'b1;
    assign active[U_CH3_B] = 1'b1;
    assign active[U_CH3_D] = ~buf_mode_r;

    // ========================================================
    // Units
    // ========================================================
    genvar g;
    generate
        for (g = 0; g < N_UNIT; g++) begin : g_unit
            cio_pin_sync u_sync (
                .i_clk_sys (i_clk_sys),
                .i_sys_rst (i_sys_rst),
                .i_pin     (pin_in[g]),
                .o_level   (pin_sync[g]),
                .o_rise    (rise[g]),
                .o_fall    (fall[g])
            );

            // A match counts once, when the counter arrives at the value
            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    prev_r[g] <= '0;
                end else begin
                    prev_r[g] <= count[g];
                end
            end
            assign match[g] = (count[g] != prev_r[g]) &&
                              (count[g] == greg_r[g]);

            // Capture beats a software write in the same cycle
            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    greg_r[g] <= GREG_RST;
                end else if (capture[g]) begin
                    greg_r[g] <= count[g];
                end else if (greg_wr[g]) begin
                    greg_r[g] <= i_wdata[CNT_W-1:0];
                end
            end

            // Channel 2 has no cascade source, so bit 6 stays ignored
            cio_unit #(
                .CASCADE (g != U_CH2_B)
            ) u_unit (
                .i_clk_sys  (i_clk_sys),
                .i_sys_rst  (i_sys_rst),
                .i_wr       (ctl_wr[g]),
                .i_wdata    (i_wdata[FLD_MSB:FLD_LSB]),
                .i_active   (active[g]),
                .i_match    (match[g]),
                .i_rise     (rise[g]),
                .i_fall     (fall[g]),
                .i_casc_evt (casc_evt),
                .o_ctl      (ctl[g]),
                .o_pin_lvl  (pin_lvl[g]),
                .o_pin_oe_n (pin_oe_n[g]),
                .o_capture  (capture[g])
            );
        end
    endgenerate

    // ========================================================
    // Read path
    // ========================================================
    // Fields for registers A and C are not held here and read zero
    always_comb begin
        rdata_nxt = '0;
        if (i_rd) begin
            if (i_addr == OFS_CH2_IOC)
                rdata_nxt[FLD_MSB:FLD_LSB] = ctl[U_CH2_B];
            else if (i_addr == OFS_CH3_IOC_HIGH)
                rdata_nxt[FLD_MSB:FLD_LSB] = ctl[U_CH3_B];
            else if (i_addr == OFS_CH3_IOC_LOW)
                rdata_nxt[FLD_MSB:FLD_LSB] = ctl[U_CH3_D];
            else if (i_addr == OFS_CH3_MODE)
                rdata_nxt[BUF_MODE_BIT] = buf_mode_r;
            else if (i_addr == OFS_CH4_CNT_CTL)
                rdata_nxt[PSC_MSB:PSC_LSB] = psc_r;
            else if (i_addr == OFS_CH2_GREG_B)
                rdata_nxt[CNT_W-1:0] = greg_r[U_CH2_B];
            else if (i_addr == OFS_CH3_GREG_B)
                rdata_nxt[CNT_W-1:0] = greg_r[U_CH3_B];
            else if (i_addr == OFS_CH3_GREG_D)
                rdata_nxt[CNT_W-1:0] = greg_r[U_CH3_D];
            else if (i_addr == OFS_PIN_STATUS) begin
                rdata_nxt[ST_LVL_LSB +: N_UNIT] = pin_lvl;
                rdata_nxt[ST_OEN_LSB +: N_UNIT] = pin_oe_n;
                rdata_nxt[ST_PIN_LSB +: N_UNIT] = pin_sync;
            end
        end
    end

    // Data valid only in the cycle after the strobe
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ========================================================
    // Outputs
    // ========================================================
    assign o_rdata          = rdata_r;
    assign o_ch2_pin_b      = pin_lvl[U_CH2_B];
    assign o_ch2_pin_b_oe_n = pin_oe_n[U_CH2_B];
    assign o_ch3_pin_b      = pin_lvl[U_CH3_B];
    assign o_ch3_pin_b_oe_n = pin_oe_n[U_CH3_B];
    assign o_ch3_pin_d      = pin_lvl[U_CH3_D];
    assign o_ch3_pin_d_oe_n = pin_oe_n[U_CH3_D];
    assign o_ch2_capture_b  = capture[U_CH2_B];
    assign o_ch3_capture_b  = capture[U_CH3_B];
    assign o_ch3_capture_d  = capture[U_CH3_D];
endmodule // cio_top

// ===== core/cio_pkg.sv
package cio_pkg;

    // ========================================================
    // Bus shape
    // ========================================================
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W  = 16;
    localparam int CTL_W  = 4;
    localparam int N_UNIT = 3;

    // ========================================================
    // Register offsets
    // ========================================================
    localparam logic [ADDR_W-1:0] OFS_CH2_IOC      = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CH3_IOC_HIGH = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_CH3_IOC_LOW  = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_CH3_MODE     = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_CH4_CNT_CTL  = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_CH2_GREG_B   = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_CH3_GREG_B   = 4'h6;
    localparam logic [ADDR_W-1:0] OFS_CH3_GREG_D   = 4'h7;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATUS   = 4'h8;

    // ========================================================
    // Field positions
    // ========================================================
    localparam int FLD_LSB       = 4;
    localparam int FLD_MSB       = 7;
    localparam int BUF_MODE_BIT  = 5;
    localparam int PSC_MSB       = 2;
    localparam int PSC_LSB       = 0;
    localparam int ST_LVL_LSB    = 0;
    localparam int ST_OEN_LSB    = 3;
    localparam int ST_PIN_LSB    = 6;

    // ========================================================
    // Reset values and the undivided prescale code
    // ========================================================
    localparam logic [CTL_W-1:0]  CTL_RST  = 4'h0;
    localparam logic [CNT_W-1:0]  GREG_RST = 16'hFFFF;
    localparam logic [2:0]        PSC_RST  = 3'h0;
    localparam logic [2:0]        PSC_UNDIVIDED = 3'h0;

    // Unit indexes
    localparam int U_CH2_B = 0;
    localparam int U_CH3_B = 1;
    localparam int U_CH3_D = 2;

    // Role picked by the control field
    typedef enum logic [2:0] {
        ROLE_OFF = 3'b001,
        ROLE_CMP = 3'b010,
        ROLE_CAP = 3'b100
    } cio_role_t;

endpackage

// ===== core/cio_pin_sync.sv
`timescale 1ns/1ps
module cio_pin_sync (
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    input  wire logic i_pin,
    output logic      o_level,
    output logic      o_rise,
    output logic      o_fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Only sync_r reads meta_r
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            meta_r <= i_pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign o_level = sync_r;
    assign o_rise  = sync_r & ~prev_r;
    assign o_fall  = ~sync_r & prev_r;
endmodule // cio_pin_sync

// ===== core/cio_unit.sv
`timescale 1ns/1ps
module cio_unit #(
    parameter logic CASCADE = 1'b0
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_sys_rst,
    input  wire logic                       i_wr,
    input  wire logic [cio_pkg::CTL_W-1:0]  i_wdata,
    input  wire logic                       i_active,
    input  wire logic                       i_match,
    input  wire logic                       i_rise,
    input  wire logic                       i_fall,
    input  wire logic                       i_casc_evt,
    output logic      [cio_pkg::CTL_W-1:0]  o_ctl,
    output logic                            o_pin_lvl,
    output logic                            o_pin_oe_n,
    output logic                            o_capture
);
    import cio_pkg::*;

    logic [CTL_W-1:0] ctl_r;
    logic [CTL_W-1:0] ctl_nxt;
    logic             lvl_r;
    logic             oe_n_r;
    cio_role_t        role;
    cio_role_t        role_nxt;

    function automatic cio_role_t decode(input logic [CTL_W-1:0] c);
        if (c[3])
            decode = ROLE_CAP;
        else if (c[1:0] == 2'h0)
            decode = ROLE_OFF;
        else
            decode = ROLE_CMP;
    endfunction

    assign ctl_nxt  = i_wr ? i_wdata : ctl_r;
    assign role     = decode(ctl_r);
    assign role_nxt = decode(ctl_nxt);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl_r <= CTL_RST;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    // ========================================================
    // Compare output
    // ========================================================
    // Initial level lands on the write itself, not on a match
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lvl_r <= 1'b0;
        end else if (i_wr && role_nxt == ROLE_CMP) begin
            lvl_r <= i_wdata[2];
        end else if (i_active && role == ROLE_CMP && i_match) begin
            case (ctl_r[1:0])
                2'h1: lvl_r <= 1'b0;
                2'h2: lvl_r <= 1'b1;
                2'h3: lvl_r <= ~lvl_r;
                default: lvl_r <= lvl_r;
            endcase
        end
    end

    // Buffer use of the register keeps the pin released
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            oe_n_r <= 1'b1;
        end else begin
            oe_n_r <= ~(i_active && role_nxt == ROLE_CMP);
        end
    end

    // ========================================================
    // Capture source and edge
    // ========================================================
    always_comb begin
        o_capture = 1'b0;
        case (role)
            ROLE_CAP: begin
                if (!i_active)
                    o_capture = 1'b0;
                else if (CASCADE && ctl_r[2])
                    o_capture = i_casc_evt;
                else if (ctl_r[1])
                    o_capture = i_rise | i_fall;
                else if (ctl_r[0])
                    o_capture = i_fall;
                else
                    o_capture = i_rise;
            end
            default: o_capture = 1'b0;
        endcase
    end

    assign o_ctl      = ctl_r;
    assign o_pin_lvl  = lvl_r;
    assign o_pin_oe_n = oe_n_r;
endmodule // cio_unit

// ===== testbench/cio_top_props.sv
`timescale 1ns/1ps
module cio_top_props
    import cio_pkg::*;
(
    input  wire logic               i_clk_sys,
    input  wire logic               i_sys_rst,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic [DATA_W-1:0]  i_wdata,
    input  wire logic               i_wr,
    input  wire logic               i_ch2_pin_b,
    input  wire logic               i_ch4_count_step,
    input  wire logic               o_ch2_pin_b,
    input  wire logic               o_ch2_pin_b_oe_n,
    input  wire logic               o_ch2_capture_b,
    input  wire logic               o_ch3_capture_b,
    input  wire logic               o_ch3_capture_d
);
    // ========================================================
    // Shadow of the fields that steer the pins and the captures
    // ========================================================
    logic [3:0] ctl2_r;
    logic [3:0] ctl3b_r;
    logic [3:0] ctl3d_r;
    logic [2:0] psc_r;
    logic       buf_r;
    logic       wr2;

    assign wr2 = i_wr && (i_addr == OFS_CH2_IOC);

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctl2_r  <= CTL_RST;
            ctl3b_r <= CTL_RST;
            ctl3d_r <= CTL_RST;
            psc_r   <= PSC_RST;
            buf_r   <= 1'b0;
        end else if (i_wr) begin
            case (i_addr)
                OFS_CH2_IOC:      ctl2_r  <= i_wdata[FLD_MSB:FLD_LSB];
                OFS_CH3_IOC_HIGH: ctl3b_r <= i_wdata[FLD_MSB:FLD_LSB];
                OFS_CH3_IOC_LOW:  ctl3d_r <= i_wdata[FLD_MSB:FLD_LSB];
                OFS_CH3_MODE:     buf_r   <= i_wdata[BUF_MODE_BIT];
                OFS_CH4_CNT_CTL:  psc_r   <= i_wdata[PSC_MSB:PSC_LSB];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    // ========================================================
    // Assertions
    // ========================================================
    AST_CMP_INIT: assert property (
        wr2 && !i_wdata[7] && i_wdata[5:4] != 2'b00 |=>
        !o_ch2_pin_b_oe_n && o_ch2_pin_b == $past(i_wdata[6]))
        else $error("initial level not applied after control write");
    AST_PIN_OFF: assert property (
        wr2 && (i_wdata[7] || i_wdata[5:4] == 2'b00) |=> o_ch2_pin_b_oe_n)
        else $error("pin driven while output disabled");
    AST_OE_CAUSE: assert property (
        $changed(o_ch2_pin_b_oe_n) |-> $past(wr2))
        else $error("output enable moved without a control write");
    AST_NO_CAP_CMP: assert property (
        !ctl2_r[3] |-> !o_ch2_capture_b)
        else $error("capture in compare mode");
    AST_RISE_CAP: assert property (
        ctl2_r[3] && ctl2_r[1:0] == 2'b00 && $rose(i_ch2_pin_b)
        |-> ##[1:4] o_ch2_capture_b)
        else $error("rising pin edge not captured");
    AST_CASC_B: assert property (
        ctl3b_r[3:2] == 2'b11 && psc_r != PSC_UNDIVIDED && i_ch4_count_step
        |-> o_ch3_capture_b)
        else $error("cascade capture missing on unit B");
    AST_CASC_D: assert property (
        ctl3d_r[3:2] == 2'b11 && psc_r != PSC_UNDIVIDED && !buf_r &&
        i_ch4_count_step |-> o_ch3_capture_d)
        else $error("cascade capture missing on unit D");
    AST_PSC0: assert property (
        ctl3b_r[3:2] == 2'b11 && psc_r == PSC_UNDIVIDED |-> !o_ch3_capture_b)
        else $error("cascade capture with undivided clock");
    AST_BUF_D: assert property (
        buf_r |-> !o_ch3_capture_d)
        else $error("unit D captured in buffer mode");

    COV_CASC: cover property (i_ch4_count_step && o_ch3_capture_b);
    COV_PIN_CAP: cover property (o_ch2_capture_b);
    COV_DRIVE: cover property ($fell(o_ch2_pin_b_oe_n));
endmodule // cio_top_props

// ===== testbench/cio_far_end.sv
`timescale 1ns/1ps
module cio_far_end
    import cio_pkg::*;
(
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_run,
    input  wire logic [cio_pkg::CNT_W-1:0]  i_base,
    input  wire logic [2:0]                 i_pins,
    input  wire logic                       i_step_req,
    output logic      [cio_pkg::CNT_W-1:0]  o_count,
    output logic      [2:0]                 o_pins,
    output logic                            o_step
);
    // ========================================================
    // Counter and pin drivers
    // ========================================================
    // Counter parks on the base so captured values are exact
    always_ff @(posedge i_clk_sys) begin
        o_count <= i_run ? o_count + 16'h0001 : i_base;
    end

    always_ff @(posedge i_clk_sys) begin
        o_pins <= i_pins;
        o_step <= i_step_req;
    end
endmodule // cio_far_end

// ===== testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import cio_pkg::*;
    logic              clk_sys;
    logic              sys_rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] rd_q;
    logic              wr;
    logic              rd;
    logic              run;
    logic              step_req;
    logic              oe;
    logic [CNT_W-1:0]  base;
    logic [CNT_W-1:0]  count;
    logic [2:0]        pins;
    logic [2:0]        pin_q;
    logic              step;
    logic [3:0]        cd;
    wire  [2:0]        lvl_o;
    wire  [2:0]        oen_o;
    int                err_total;
    int                compares;
    logic [3:0]        mcode [3] = '{4'h5, 4'h2, 4'h3};
    logic              mexp  [3] = '{1'b0, 1'b1, 1'b1};
    logic [7:0]        ccode [6] = '{8'hC0, 8'hC0, 8'h90, 8'h90,
                                     8'hB0, 8'hB0};
    logic              clvl  [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    logic [15:0]       cexp  [6] = '{16'h1111, 16'h1111, 16'h1111,
                                     16'h4444, 16'h5555, 16'h6666};

    cio_top dut_u (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_ch2_count(count), .i_ch3_count(count), .i_ch4_count_step(step),
        .i_ch2_pin_b(pin_q[0]), .o_ch2_pin_b(lvl_o[0]),
        .o_ch2_pin_b_oe_n(oen_o[0]),
        .i_ch3_pin_b(pin_q[1]), .o_ch3_pin_b(lvl_o[1]),
        .o_ch3_pin_b_oe_n(oen_o[1]),
        .i_ch3_pin_d(pin_q[2]), .o_ch3_pin_d(lvl_o[2]),
        .o_ch3_pin_d_oe_n(oen_o[2]),
        .o_ch2_capture_b(), .o_ch3_capture_b(), .o_ch3_capture_d());

    cio_far_end far_u (.i_clk_sys(clk_sys), .i_run(run), .i_base(base),
        .i_pins(pins), .i_step_req(step_req), .o_count(count),
        .o_pins(pin_q), .o_step(step));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // ========================================================
    // Access and check tasks
    // ========================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] d;
        rd_reg(a, d);
        check(d, exp);
    endtask

    // Pin and counter settle before the sync chain sees the edge
    task automatic pin_cap(input int idx, input logic lvl,
                           input logic [15:0] v);
        @(posedge clk_sys);
        pins[idx] <= lvl;
        base <= v;
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic step_cap(input logic [15:0] v);
        @(posedge clk_sys);
        base <= v;
        step_req <= 1'b1;
        @(posedge clk_sys);
        step_req <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic close_out();
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ========================================================
    // Main sequence
    // ========================================================
    initial begin
        sys_rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        run = 1'b0;
        base = '0;
        pins = '0;
        step_req = 1'b0;
        err_total = 0;
        compares = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wr_reg(4'h9, 16'h00F0);
        for (int i = 0; i < 16; i++)
            rd_chk(4'(i), (i == 8) ? 16'h0038 :
                   ((i > 4 && i < 8) ? GREG_RST : 16'h0000));
        for (int c = 0; c < 8; c++) begin
            cd = 4'(c);
            oe = (cd[1:0] == 2'b00);
            wr_reg(OFS_CH2_IOC, {8'h00, cd, 4'h0});
            rd_chk(OFS_CH2_IOC, {8'h00, cd, 4'h0});
            rd_reg(OFS_PIN_STATUS, rd_q);
            check(16'({rd_q[ST_OEN_LSB], rd_q[0] & ~oe}),
                  16'({oe, cd[2] & ~oe}));
            check(16'({oen_o[0], lvl_o[0] & ~oe}),
                  16'({oe, cd[2] & ~oe}));
        end
        wr_reg(OFS_CH2_GREG_B, 16'h0010);
        for (int k = 0; k < 3; k++) begin
            wr_reg(OFS_CH2_IOC, {8'h00, mcode[k], 4'h0});
            rd_reg(OFS_PIN_STATUS, rd_q);
            check(16'(rd_q[0]), 16'(mcode[k][2]));
            @(posedge clk_sys);
            run <= 1'b1;
            repeat (40) @(posedge clk_sys);
            run <= 1'b0;
            rd_reg(OFS_PIN_STATUS, rd_q);
            check(16'(rd_q[0]), 16'(mexp[k]));
        end
        for (int k = 0; k < 6; k++) begin
            wr_reg(OFS_CH2_IOC, {8'h00, ccode[k]});
            pin_cap(0, clvl[k], 16'(k + 1) * 16'h1111);
            rd_chk(OFS_CH2_GREG_B, cexp[k]);
        end
        wr_reg(OFS_CH3_IOC_LOW, 16'h0080);
        pin_cap(2, 1'b1, 16'h7777);
        rd_chk(OFS_CH3_GREG_D, 16'h7777);
        wr_reg(OFS_CH4_CNT_CTL, 16'h0001);
        wr_reg(OFS_CH3_IOC_HIGH, 16'h00C0);
        wr_reg(OFS_CH3_IOC_LOW, 16'h00C0);
        step_cap(16'h0ABC);
        rd_chk(OFS_CH3_GREG_B, 16'h0ABC);
        rd_chk(OFS_CH3_GREG_D, 16'h0ABC);
        wr_reg(OFS_CH4_CNT_CTL, 16'h0000);
        step_cap(16'h0DEF);
        rd_chk(OFS_CH3_GREG_B, 16'h0ABC);
        rd_chk(OFS_CH3_GREG_D, 16'h0ABC);
        wr_reg(OFS_CH4_CNT_CTL, 16'h0001);
        wr_reg(OFS_CH3_MODE, 16'h0020);
        step_cap(16'h0777);
        rd_chk(OFS_CH3_GREG_B, 16'h0777);
        rd_chk(OFS_CH3_GREG_D, 16'h0ABC);
        wr_reg(OFS_CH3_IOC_LOW, 16'h0050);
        rd_reg(OFS_PIN_STATUS, rd_q);
        check(16'(rd_q[ST_OEN_LSB + 2]), 16'h0001);
        // Pin D takes its held initial level once buffer use ends
        wr_reg(OFS_CH3_IOC_HIGH, 16'h0070);
        wr_reg(OFS_CH3_MODE, 16'h0000);
        repeat (2) @(negedge clk_sys);
        check(16'({oen_o[2:1], lvl_o[2:1]}), 16'h0003);
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        close_out();
    end
endmodule // testbench

bind cio_top cio_top_props chk_u (.i_clk_sys, .i_sys_rst, .i_addr,
    .i_wdata, .i_wr, .i_ch2_pin_b, .i_ch4_count_step, .o_ch2_pin_b,
    .o_ch2_pin_b_oe_n, .o_ch2_capture_b, .o_ch3_capture_b,
    .o_ch3_capture_d);
